/* fsrw_regs.vh */
// Opcodes, timing figures and derived cycle counts for the suspend/resume gate
`ifndef FSRW_REGS_VH
`define FSRW_REGS_VH

// ------------------------------------------------------------
// System clock
// ------------------------------------------------------------
`define FSRW_CLK_MHZ 125

// ------------------------------------------------------------
// Latencies (ns); counts round down because both are upper bounds
// ------------------------------------------------------------
`define FSRW_T_SUSP_NS 20000
`define FSRW_T_RES_NS 10000
`define FSRW_SUSP_CYC ((`FSRW_T_SUSP_NS * `FSRW_CLK_MHZ) / 1000)
`define FSRW_RES_CYC ((`FSRW_T_RES_NS * `FSRW_CLK_MHZ) / 1000)
`define FSRW_CNT_W 12

// ------------------------------------------------------------
// Opcodes handled locally
// ------------------------------------------------------------
`define FSRW_OP_RESUME 8'hd0
`define FSRW_OP_WR_EN 8'h06
`define FSRW_OP_WR_DIS 8'h04
`define FSRW_OP_SUSPEND 8'hb0
`define FSRW_OP_RESET 8'hf0

// ------------------------------------------------------------
// Opcodes only classified and forwarded
// ------------------------------------------------------------
`define FSRW_OP_RD_SLOW 8'h03
`define FSRW_OP_RD_FAST 8'h0b
`define FSRW_OP_RD_FAST2 8'h1b
`define FSRW_OP_RD_DUAL 8'h3b
`define FSRW_OP_RD_PROT 8'h3c
`define FSRW_OP_RD_LOCK 8'h35
`define FSRW_OP_RD_OTP 8'h77
`define FSRW_OP_RD_STAT 8'h05
`define FSRW_OP_RD_ID 8'h9f
`define FSRW_OP_PROG 8'h02
`define FSRW_OP_PROG_DUAL 8'ha2
`define FSRW_OP_ERASE_4K 8'h20
`define FSRW_OP_ERASE_32K 8'h52
`define FSRW_OP_ERASE_64K 8'hd8
`define FSRW_OP_CHIP_A 8'h60
`define FSRW_OP_CHIP_B 8'hc7
`define FSRW_OP_PROTECT 8'h36
`define FSRW_OP_UNPROTECT 8'h39
`define FSRW_OP_LOCKDOWN 8'h33
`define FSRW_OP_FREEZE 8'h34
`define FSRW_OP_PROG_OTP 8'h9b
`define FSRW_OP_WR_STAT1 8'h01
`define FSRW_OP_WR_STAT2 8'h31
`define FSRW_OP_WR_CFG 8'h3f
`define FSRW_OP_DPD 8'hb9
`define FSRW_OP_DPD_EXIT 8'hab

// ------------------------------------------------------------
// Suspend classes of an opcode
// ------------------------------------------------------------
`define FSRW_CLS_ANY 2'h1
`define FSRW_CLS_ESUSP 2'h2
`define FSRW_CLS_NEVER 2'h3

`endif

/* fsrw_ctrl.v */
// Command gate: suspend/resume sequencing and write-enable latch behind the serial port
//
// Function
// - Reset in erase suspend: erase block lost
// - Reset in program suspend: only page lost
// - Forbidden command in suspend: ignored, latches kept
// - Program suspend: only reads, resume, reset, ID
// - Erase suspend adds program, suspend, WE, WD
// - Erase, protect, lockdown, OTP, status write refused
// - Resume D0h decoded regardless of write latch
// - Resume restarts, clears flag, shows busy
// - Local commands need whole aligned opcode bytes
// - Both suspended: program resumes first, erase later
// - Suspend ignored while resume still in progress
// - Write-class commands need write latch set
// - Opcode 06h sets write latch at frame end
// - Opcode 04h clears write latch at frame end
// - Suspend B0h halts operation, sets flag, ready
// - Reads of suspended sector give undefined data
// - Program/erase into other suspended sector aborts
`timescale 1ns/1ns
`include "fsrw_regs.vh"

module fsrw_ctrl (
  input wire i_clk_sys,
  input wire i_srst,
  input wire i_spi_cs_n,
  input wire i_spi_sck,
  input wire i_spi_mosi,
  input wire i_op_start,
  input wire i_op_erase,
  input wire [4:0] i_op_sector,
  input wire i_op_done,
  input wire i_wel_clear,
  input wire i_read_active,
  input wire [4:0] i_read_sector,
  output reg o_gate_valid,
  output reg o_gate_ok,
  output reg [7:0] o_gate_opcode,
  output reg o_engine_halt,
  output reg o_engine_restart,
  output reg o_engine_restart_erase,
  output reg o_op_abort,
  output reg o_erase_block_lost,
  output reg o_program_page_lost,
  output reg o_read_undefined,
  output reg o_write_enable_latch,
  output reg o_program_suspended_flag,
  output reg o_erase_suspended_flag,
  output reg o_ready_busy_flag
);

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam integer SUSP_CYC_I = `FSRW_SUSP_CYC; // Halt latency, full width
  localparam integer RES_CYC_I = `FSRW_RES_CYC; // Restart latency, full width
  // Cut to the counter width on purpose; both figures fit in twelve bits
  localparam [`FSRW_CNT_W-1:0] SUSP_CYC = SUSP_CYC_I[`FSRW_CNT_W-1:0]; // Halt latency in cycles
  localparam [`FSRW_CNT_W-1:0] RES_CYC = RES_CYC_I[`FSRW_CNT_W-1:0]; // Restart latency in cycles
  localparam [2:0] ST_IDLE = 3'h1; // Nothing in flight
  localparam [2:0] ST_SUSP = 3'h2; // Halting the running operation
  localparam [2:0] ST_RES = 3'h4; // Restarting a suspended operation

  // ------------------------------------------------------------
  // Opcode classification
  // ------------------------------------------------------------
  // Class under suspension; unknown opcodes are treated as forbidden
  function [1:0] op_class;
    input [7:0] op;
    begin
      case (op)
        `FSRW_OP_RD_SLOW, `FSRW_OP_RD_FAST, `FSRW_OP_RD_FAST2, `FSRW_OP_RD_DUAL,
        `FSRW_OP_RESUME, `FSRW_OP_RD_PROT, `FSRW_OP_RD_LOCK, `FSRW_OP_RD_OTP,
        `FSRW_OP_RD_STAT, `FSRW_OP_RESET, `FSRW_OP_RD_ID: op_class = `FSRW_CLS_ANY;
        `FSRW_OP_PROG, `FSRW_OP_PROG_DUAL, `FSRW_OP_SUSPEND,
        `FSRW_OP_WR_EN, `FSRW_OP_WR_DIS: op_class = `FSRW_CLS_ESUSP;
        default: op_class = `FSRW_CLS_NEVER;
      endcase
    end
  endfunction

  // Commands that only run with the write latch set
  function needs_wel;
    input [7:0] op;
    begin
      case (op)
        `FSRW_OP_PROG, `FSRW_OP_PROG_DUAL, `FSRW_OP_ERASE_4K, `FSRW_OP_ERASE_32K,
        `FSRW_OP_ERASE_64K, `FSRW_OP_CHIP_A, `FSRW_OP_CHIP_B, `FSRW_OP_PROTECT,
        `FSRW_OP_UNPROTECT, `FSRW_OP_LOCKDOWN, `FSRW_OP_FREEZE, `FSRW_OP_PROG_OTP,
        `FSRW_OP_WR_STAT1, `FSRW_OP_WR_STAT2, `FSRW_OP_WR_CFG: needs_wel = 1'b1;
        default: needs_wel = 1'b0; // Suspend, resume and reads ignore the latch
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] cs_sync_q; // [0] is only read by [1]
  reg [2:0] sck_sync_q; // Third stage gives the edge history
  reg [1:0] mosi_sync_q; // Same depth as the clock's second stage

  // Two flops on every pin, a third on select and clock for edge detection
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      cs_sync_q <= 3'h7;
      sck_sync_q <= 3'h0;
      mosi_sync_q <= 2'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], i_spi_cs_n};
      sck_sync_q <= {sck_sync_q[1:0], i_spi_sck};
      mosi_sync_q <= {mosi_sync_q[0], i_spi_mosi};
    end
  end

  wire cs_low = ~cs_sync_q[1]; // Frame in progress
  wire cs_rise = cs_sync_q[1] & ~cs_sync_q[2]; // Frame end
  wire sck_rise = sck_sync_q[1] & ~sck_sync_q[2]; // Sample point, modes 0 and 3

  // ------------------------------------------------------------
  // Frame receiver
  // ------------------------------------------------------------
  reg [2:0] bit_cnt_q; // Bits modulo eight
  reg byte_seen_q; // At least one whole byte in this frame
  reg [7:0] shift_q; // Opcode shifter, keeps shifting past the first byte
  reg op_ok_q; // Opcode passed the gate
  reg [7:0] op_q; // Captured opcode

  wire op_byte_done = sck_rise & cs_low & ~byte_seen_q & (bit_cnt_q == 3'h7);
  wire [7:0] op_now = {shift_q[6:0], mosi_sync_q[1]};
  wire susp_any = o_program_suspended_flag | o_erase_suspended_flag;
  wire [1:0] cls_now = op_class(op_now);
  // A command passes when no suspension forbids it and its latch demand is met
  wire allow_now = (~susp_any | (cls_now == `FSRW_CLS_ANY) |
                   ((cls_now == `FSRW_CLS_ESUSP) & ~o_program_suspended_flag)) &
                   (~needs_wel(op_now) | o_write_enable_latch);
  // Local commands act only on a whole, aligned frame
  wire frame_ok = cs_rise & byte_seen_q & (bit_cnt_q == 3'h0) & op_ok_q;

  // Edge counting restarts whenever the chip is deselected
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      bit_cnt_q <= 3'h0;
      byte_seen_q <= 1'b0;
      shift_q <= 8'h00;
      op_ok_q <= 1'b0;
      op_q <= 8'h00;
    end else if (!cs_low) begin
      bit_cnt_q <= 3'h0;
      byte_seen_q <= cs_rise & byte_seen_q; // Held one cycle for the end check
      op_ok_q <= cs_rise & op_ok_q;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= op_now;
      if (op_byte_done) begin
        byte_seen_q <= 1'b1;
        op_q <= op_now;
        op_ok_q <= allow_now;
      end
    end
  end

  // Gate verdict towards the array engines, once per frame
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_gate_valid <= 1'b0;
      o_gate_ok <= 1'b0;
      o_gate_opcode <= 8'h00;
    end else begin
      o_gate_valid <= op_byte_done;
      if (op_byte_done) begin
        o_gate_ok <= allow_now;
        o_gate_opcode <= op_now;
      end
    end
  end

  // ------------------------------------------------------------
  // Suspend / resume sequencer
  // ------------------------------------------------------------
  reg [2:0] st_q; // One-hot state
  reg [`FSRW_CNT_W-1:0] cnt_q; // Latency countdown
  reg run_q; // Program or erase running
  reg run_erase_q; // Running operation is an erase
  reg [4:0] run_sector_q; // Sector of the running operation
  reg [4:0] ps_sector_q; // Sector with a suspended program
  reg [4:0] es_sector_q; // Sector with a suspended erase

  wire is_cmd_reset = frame_ok & (op_q == `FSRW_OP_RESET);
  wire is_cmd_susp = frame_ok & (op_q == `FSRW_OP_SUSPEND);
  wire is_cmd_res = frame_ok & (op_q == `FSRW_OP_RESUME);
  // Engine start aimed at the sector of the opposite kind of suspension
  wire conflict = i_op_start & ((~i_op_erase & o_erase_suspended_flag &
                  (i_op_sector == es_sector_q)) |
                  (i_op_erase & o_program_suspended_flag &
                  (i_op_sector == ps_sector_q)));

  // Latency timers run on the system clock; the link clock may stop after the frame
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q <= ST_IDLE;
      cnt_q <= {`FSRW_CNT_W{1'b0}};
      run_q <= 1'b0;
      run_erase_q <= 1'b0;
      run_sector_q <= 5'h00;
      ps_sector_q <= 5'h00;
      es_sector_q <= 5'h00;
      o_program_suspended_flag <= 1'b0;
      o_erase_suspended_flag <= 1'b0;
      o_engine_halt <= 1'b0;
      o_engine_restart <= 1'b0;
      o_engine_restart_erase <= 1'b0;
      o_op_abort <= 1'b0;
      o_erase_block_lost <= 1'b0;
      o_program_page_lost <= 1'b0;
    end else begin
      o_engine_halt <= 1'b0;
      o_engine_restart <= 1'b0;
      o_op_abort <= 1'b0;
      o_erase_block_lost <= 1'b0;
      o_program_page_lost <= 1'b0;
      if (is_cmd_reset) begin
        // Reset abandons whatever is suspended or running
        o_erase_block_lost <= o_erase_suspended_flag;
        o_program_page_lost <= o_program_suspended_flag;
        o_program_suspended_flag <= 1'b0;
        o_erase_suspended_flag <= 1'b0;
        run_q <= 1'b0;
        st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (is_cmd_susp && run_q) begin
              // Program already suspended never gets here: gate refused it
              st_q <= ST_SUSP;
              cnt_q <= SUSP_CYC;
              o_engine_halt <= 1'b1;
            end else if (is_cmd_res && !run_q && susp_any) begin
              st_q <= ST_RES;
              cnt_q <= RES_CYC;
              o_engine_restart <= 1'b1;
              o_engine_restart_erase <= ~o_program_suspended_flag;
            end else if (conflict) begin
              o_op_abort <= 1'b1;
            end else if (i_op_start && !run_q) begin
              run_q <= 1'b1;
              run_erase_q <= i_op_erase;
              run_sector_q <= i_op_sector;
            end else if (i_op_done) begin
              run_q <= 1'b0; // Erase stays suspended until a later resume
            end
          end
          ST_SUSP: begin
            if (cnt_q == {`FSRW_CNT_W{1'b0}}) begin
              st_q <= ST_IDLE;
              run_q <= 1'b0;
              if (run_erase_q) begin
                o_erase_suspended_flag <= 1'b1;
                es_sector_q <= run_sector_q;
              end else begin
                o_program_suspended_flag <= 1'b1;
                ps_sector_q <= run_sector_q;
              end
            end else begin
              cnt_q <= cnt_q - {{(`FSRW_CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_RES: begin
            // Suspend frames in this state fall through unheeded
            if (cnt_q == {`FSRW_CNT_W{1'b0}}) begin
              st_q <= ST_IDLE;
              run_q <= 1'b1;
              run_erase_q <= o_engine_restart_erase;
              if (o_engine_restart_erase) begin
                o_erase_suspended_flag <= 1'b0;
                run_sector_q <= es_sector_q;
              end else begin
                o_program_suspended_flag <= 1'b0;
                run_sector_q <= ps_sector_q;
              end
            end else begin
              cnt_q <= cnt_q - {{(`FSRW_CNT_W-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Write-enable latch, busy flag, read guard
  // ------------------------------------------------------------
  // Setting by 06h wins over any clear arriving in the same cycle
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_write_enable_latch <= 1'b0;
      o_ready_busy_flag <= 1'b0;
      o_read_undefined <= 1'b0;
    end else begin
      if (frame_ok && op_q == `FSRW_OP_WR_EN) begin
        o_write_enable_latch <= 1'b1;
      end else if (frame_ok && op_q == `FSRW_OP_WR_DIS) begin
        o_write_enable_latch <= 1'b0;
      end else if (conflict || i_wel_clear) begin
        o_write_enable_latch <= 1'b0;
      end
      // Busy while running or while a restart is under way
      o_ready_busy_flag <= run_q | st_q[2] | st_q[1];
      o_read_undefined <= i_read_active &
                          ((o_erase_suspended_flag & (i_read_sector == es_sector_q)) |
                          (o_program_suspended_flag & (i_read_sector == ps_sector_q)));
    end
  end

endmodule // fsrw_ctrl

/* fsrw_ctrl_chk.sv */
// Concurrent checks on the ports of the suspend/resume command gate
`timescale 1ns/1ns
`include "fsrw_regs.vh"
module fsrw_ctrl_chk (
  input wire i_clk_sys,
  input wire i_srst,
  input wire i_op_start,
  input wire i_wel_clear,
  input wire i_read_active,
  input wire o_gate_ok,
  input wire [7:0] o_gate_opcode,
  input wire o_engine_halt,
  input wire o_engine_restart,
  input wire o_engine_restart_erase,
  input wire o_op_abort,
  input wire o_erase_block_lost,
  input wire o_program_page_lost,
  input wire o_read_undefined,
  input wire o_write_enable_latch,
  input wire o_program_suspended_flag,
  input wire o_erase_suspended_flag,
  input wire o_ready_busy_flag
);
  // ----------------------------------------
  // Latency counters
  // ----------------------------------------
  wire susp = o_program_suspended_flag | o_erase_suspended_flag; // Any suspension held
  reg [11:0] halt_cnt_q; // Cycles left until a halt completes
  reg [11:0] res_cnt_q; // Cycles left until a restart completes
  // Count down from each accepted pulse; timing assertions key on the value 1, res_block_a on any nonzero value
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      halt_cnt_q <= 12'h000;
      res_cnt_q <= 12'h000;
    end else begin
      if (o_engine_halt) halt_cnt_q <= 12'(`FSRW_SUSP_CYC);
      else if (halt_cnt_q != 12'h000) halt_cnt_q <= halt_cnt_q - 12'h001;
      if (o_engine_restart) res_cnt_q <= 12'(`FSRW_RES_CYC);
      else if (res_cnt_q != 12'h000) res_cnt_q <= res_cnt_q - 12'h001;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  susp_time_a: assert property (halt_cnt_q == 12'h001 |=> susp ##1 !o_ready_busy_flag)
    else $error("suspend flag or ready not on time");
  halt_busy_a: assert property (o_engine_halt |=> o_ready_busy_flag [*8])
    else $error("busy dropped during halt");
  res_block_a: assert property (res_cnt_q != 12'h000 |-> o_ready_busy_flag && !o_engine_halt)
    else $error("halt accepted during restart");
  res_flag_a: assert property (res_cnt_q == 12'h001 |=> o_ready_busy_flag &&
    (o_engine_restart_erase ? !o_erase_suspended_flag : !o_program_suspended_flag))
    else $error("resumed flag not cleared on time");
  res_first_a: assert property (o_engine_restart && o_program_suspended_flag |->
    !o_engine_restart_erase) else $error("erase resumed before program");
  abort_wel_a: assert property (o_op_abort |-> !o_write_enable_latch && $past(i_op_start)
    && $past(susp)) else $error("bad abort");
  wel_set_a: assert property ($rose(o_write_enable_latch) |-> o_gate_ok &&
    o_gate_opcode == `FSRW_OP_WR_EN) else $error("latch set without enable");
  wel_clr_a: assert property ($fell(o_write_enable_latch) |-> o_op_abort || i_wel_clear ||
    $past(i_wel_clear) || o_gate_ok && o_gate_opcode == `FSRW_OP_WR_DIS)
    else $error("latch cleared without cause");
  lost_erase_a: assert property (o_erase_block_lost |-> $past(o_erase_suspended_flag))
    else $error("block lost without erase suspend");
  lost_page_a: assert property (o_program_page_lost |-> $past(o_program_suspended_flag))
    else $error("page lost without program suspend");
  rd_undef_a: assert property (o_read_undefined |-> $past(i_read_active) && $past(susp))
    else $error("undefined read without suspension");
  cov_halt: cover property (o_engine_halt);
  cov_res_erase: cover property (o_engine_restart ##1 o_engine_restart_erase);
  cov_abort: cover property (o_op_abort);
  cov_page: cover property (o_program_page_lost);
endmodule // fsrw_ctrl_chk

bind fsrw_ctrl fsrw_ctrl_chk u_chk (.*);

/* fsrw_host.sv */
// Serial host model that frames commands towards the gate
`timescale 1ns/1ns
module fsrw_host (
  input wire i_clk_sys,
  output reg o_cs_n,
  output reg o_sck,
  output reg o_mosi
);
  // Idle: deselected, clock parked low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end
  // ----------------------------------------
  // One frame of n bits, MSB first, 160 ns a bit
  // ----------------------------------------
  task send(input [15:0] d, input integer n);
    integer k;
    begin
      o_cs_n <= 1'b0;
      for (k = 0; k < n; k = k + 1) begin
        o_mosi <= d[15 - k];
        repeat (10) @(posedge i_clk_sys);
        o_sck <= 1'b1;
        repeat (10) @(posedge i_clk_sys);
        o_sck <= 1'b0;
      end
      repeat (10) @(posedge i_clk_sys);
      o_cs_n <= 1'b1;
      // Released line flips so a stale bit is never mistaken for data
      o_mosi <= ~o_mosi;
      repeat (10) @(posedge i_clk_sys);
    end
  endtask
endmodule // fsrw_host

/* testbench.sv */
// Self-checking bench for the suspend/resume command gate
`timescale 1ns/1ns
`include "fsrw_regs.vh"
module testbench;
  // ----------------------------------------
  // Stimulus, outputs and tallies
  // ----------------------------------------
  reg i_clk_sys = 1'b0;
  reg i_srst = 1'b1;
  reg i_op_start = 1'b0;
  reg i_op_erase = 1'b0;
  reg [4:0] i_op_sector = 5'h00;
  reg i_op_done = 1'b0;
  reg i_wel_clear = 1'b0;
  reg i_read_active = 1'b0;
  reg [4:0] i_read_sector = 5'h00;
  wire i_spi_cs_n, i_spi_sck, i_spi_mosi;
  wire o_gate_valid, o_gate_ok, o_engine_halt, o_engine_restart, o_engine_restart_erase;
  wire o_op_abort, o_erase_block_lost, o_program_page_lost, o_read_undefined;
  wire o_write_enable_latch, o_program_suspended_flag, o_erase_suspended_flag, o_ready_busy_flag;
  wire [7:0] o_gate_opcode;
  // Pulses stand one cycle, so they are tallied
  reg [7:0] n_halt = 8'h00, n_rst = 8'h00, n_abort = 8'h00, n_ebl = 8'h00, n_ppl = 8'h00;
  reg [7:0] n_gv = 8'h00;
  integer num_errors = 0;
  integer n_tests = 0;
  integer seed = 37;
  integer i;
  reg [7:0] op;
  always #4 i_clk_sys = ~i_clk_sys;
  fsrw_ctrl u_dut (.*);
  fsrw_host u_host (.i_clk_sys(i_clk_sys), .o_cs_n(i_spi_cs_n), .o_sck(i_spi_sck),
    .o_mosi(i_spi_mosi));
  // Tally every pulse output
  always @(posedge i_clk_sys) begin
    n_halt <= n_halt + {7'h00, o_engine_halt};
    n_rst <= n_rst + {7'h00, o_engine_restart};
    n_abort <= n_abort + {7'h00, o_op_abort};
    n_ebl <= n_ebl + {7'h00, o_erase_block_lost};
    n_ppl <= n_ppl + {7'h00, o_program_page_lost};
    n_gv <= n_gv + {7'h00, o_gate_valid};
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp, input [8*8:1] what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // Flags packed as latch, program, erase, busy
  task state(input [3:0] e);
    check({4'h0, o_write_enable_latch, o_program_suspended_flag, o_erase_suspended_flag,
      o_ready_busy_flag}, {4'h0, e}, "flags");
  endtask
  task start(input e, input [4:0] s);
    begin
      i_op_start <= 1'b1;
      i_op_erase <= e;
      i_op_sector <= s;
      tick(1);
      i_op_start <= 1'b0;
      tick(3);
    end
  endtask
  task suspend;
    begin
      u_host.send(16'hb000, 8);
      tick(`FSRW_SUSP_CYC + 5);
    end
  endtask
  task resume;
    begin
      u_host.send(16'hd000, 8);
      tick(`FSRW_RES_CYC + 5);
    end
  endtask
  // Verdict expected from the gate: reads always, writes only in erase suspend
  function [7:0] ok_exp(input [7:0] c, input in_es);
    case (c)
      8'h03, 8'h0b, 8'h1b, 8'h3b, 8'h3c, 8'h35, 8'h77, 8'h05, 8'h9f: ok_exp = 8'h01;
      8'h02, 8'ha2, 8'h06, 8'h04: ok_exp = {7'h00, in_es};
      default: ok_exp = 8'h00;
    endcase
  endfunction
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog sized above the roughly 63k cycles of the run, below 100k
  initial begin
    #760000;
    num_errors = num_errors + 1;
    stop_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(3);
    i_srst <= 1'b0;
    tick(2);
    u_host.send(16'h0600, 8);
    state(4'h8);
    check(n_gv, 8'h01, "gate_vld");
    u_host.send(16'h0400, 8);
    state(4'h0);
    u_host.send(16'h0600, 7);
    state(4'h0);
    u_host.send({8'h06, 8'($random(seed))}, 16);
    state(4'h8);
    u_host.send(16'h0400, 12);
    state(4'h8);
    i_wel_clear <= 1'b1;
    tick(1);
    i_wel_clear <= 1'b0;
    tick(2);
    state(4'h0);
    $display("test latch done");
    u_host.send(16'h0600, 8);
    start(1'b1, 5'h03);
    suspend;
    state(4'ha);
    for (i = 0; i < 8; i = i + 1) begin
      op = 8'($random(seed));
      // Local commands would change state, so swap them for a status read
      if (op == 8'hb0 || op == 8'hd0 || op == 8'hf0 || op == 8'h06 || op == 8'h04) op = 8'h05;
      u_host.send({op, 8'h00}, 8);
      check({7'h00, o_gate_ok}, ok_exp(op, 1'b1), "gate_ok");
      state(4'ha);
    end
    u_host.send(16'h0400, 8);
    state(4'h2);
    start(1'b0, 5'h03);
    check(n_abort, 8'h01, "abort");
    state(4'h2);
    u_host.send(16'h0600, 8);
    start(1'b0, 5'h05);
    suspend;
    state(4'he);
    $display("test erase suspend done");
    i_read_active <= 1'b1;
    i_read_sector <= 5'h05;
    tick(3);
    check({7'h00, o_read_undefined}, 8'h01, "rd_undef");
    i_read_sector <= 5'h07;
    tick(3);
    check({7'h00, o_read_undefined}, 8'h00, "rd_undef");
    i_read_active <= 1'b0;
    for (i = 0; i < 256; i = i + 1) begin
      op = i[7:0];
      if (op != 8'hb0 && op != 8'hd0 && op != 8'hf0) begin
        u_host.send({op, 8'h00}, 8);
        check({7'h00, o_gate_ok}, ok_exp(op, 1'b0), "gate_ok");
        check(o_gate_opcode, op, "opcode");
        state(4'he);
      end
    end
    $display("test command table done");
    u_host.send(16'hd000, 8);
    check(n_rst, 8'h01, "restart");
    u_host.send(16'hb000, 8);
    tick(`FSRW_RES_CYC + 5);
    check(n_halt, 8'h02, "halts");
    check({7'h00, o_engine_restart_erase}, 8'h00, "res_kind");
    state(4'hb);
    i_op_done <= 1'b1;
    tick(1);
    i_op_done <= 1'b0;
    resume;
    check({7'h00, o_engine_restart_erase}, 8'h01, "res_kind");
    state(4'h9);
    $display("test resume done");
    // Full resume latency already waited before suspending again
    suspend;
    state(4'ha);
    u_host.send(16'hf000, 8);
    check(n_ebl, 8'h01, "blk_lost");
    state(4'h8);
    start(1'b0, 5'h09);
    suspend;
    state(4'hc);
    u_host.send(16'hf000, 8);
    check(n_ppl, 8'h01, "pg_lost");
    state(4'h8);
    $display("test reset in suspend done");
    stop_test;
  end
endmodule // testbench
